// *** pkg/adcsc_pkg.sv ***
package adcsc_pkg;
    // Byte offsets of the register words on the APB.
    localparam logic [7:0] OFS_STOP = 8'h00;
    localparam logic [7:0] OFS_CSR = 8'h04;
    localparam logic [7:0] OFS_START = 8'h08;
    localparam logic [7:0] OFS_TRIG = 8'h0c;
    localparam logic [7:0] OFS_RES0 = 8'h10;
    localparam logic [7:0] OFS_RES1 = 8'h14;
    localparam logic [7:0] OFS_RES2 = 8'h18;
    localparam logic [7:0] OFS_RES3 = 8'h1c;

    // Field positions in conv_control_status.
    localparam int BIT_FLAG = 15;
    localparam int BIT_IE = 14;
    localparam int BIT_TRGEN = 11;
    localparam int BIT_FLAGCTL = 9;
    localparam int BIT_STATES = 8;
    localparam int CKS_LSB = 6;
    localparam int MODE_LSB = 4;
    localparam int BIT_CONT = 3;
    localparam int CHSEL_LSB = 0;
    localparam logic [15:0] CSR_WMASK = 16'h4bff;

    // Field positions in the other registers.
    localparam int BIT_START = 13;
    localparam int BIT_STOP0 = 0;
    localparam int TRG_U0_LSB = 4;
    localparam int TRG_G1_LSB = 8;

    // Reset values.
    localparam logic [7:0] STOP_RST = 8'hff;
    localparam logic [15:0] CSR_RST = 16'h0000;
    localparam logic [15:0] TRIG_RST = 16'h0000;

    // Conversion modes.
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_SCAN4 = 2'h1;
    localparam logic [1:0] MODE_SCAN2 = 2'h2;

    // Conversion clock dividers and conversion lengths in states.
    localparam logic [4:0] DIV_CKS0 = 5'h04;
    localparam logic [4:0] DIV_CKS1 = 5'h08;
    localparam logic [4:0] DIV_CKS2 = 5'h10;
    localparam logic [4:0] DIV_CKS3 = 5'h02;
    localparam logic [6:0] LEN_SHORT = 7'h32;
    localparam logic [6:0] LEN_LONG = 7'h40;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_WAIT} adcsc_seq_e;
endpackage : adcsc_pkg

// *** pkg/adcsc_res_if.sv ***
`timescale 1ns/1ps
interface adcsc_res_if;
    logic wr_en;
    logic [1:0] wr_idx;
    logic [15:0] wr_data;
    logic [1:0] rd_idx;
    logic [15:0] rd_data;
    modport ctrl (output wr_en, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
    modport store (input wr_en, input wr_idx, input wr_data,
                   input rd_idx, output rd_data);
endinterface : adcsc_res_if

// *** rtl/adcsc_result_store.sv ***
`timescale 1ns/1ps
module adcsc_result_store
    import adcsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    adcsc_res_if.store res
);
    logic [15:0] mem_q [0:3];
    logic [15:0] rd_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                mem_q[i] <= 16'h0000;
            end
        end
        else if (res.wr_en)
        begin
            mem_q[res.wr_idx] <= res.wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_q <= 16'h0000;
        end
        else
        begin
            rd_q <= mem_q[res.rd_idx];
        end
    end

    assign res.rd_data = rd_q;

    a_result_kept: assert property (@(posedge pclk)
        disable iff (!presetn)
        res.wr_en |=> mem_q[$past(res.wr_idx)] == $past(res.wr_data))
        else $error("Result word not stored.");
endmodule : adcsc_result_store

// *** rtl/adcsc_scan_ctrl.sv ***
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - In scan mode, set end flag (bit 15) when all selected channels finish.
// - Software clears end flag by writing 0 only after reading it as 1.
// - A transfer-controller read of a result register also clears the flag while bit 14 is 1.
// - Interrupt follows end flag only while enable bit 14 is 1.
// - Trigger requests are ignored while trigger enable bit 11 is 0.
// - Bit 9 decides end-flag behaviour in two-channel scan mode.
// - Bit 8 selects conversion time; 0 gives 50 states per conversion.
// - Bits 7:6 select conversion clock; 00 is peripheral clock over four.
// - Bits 5:4 select mode; 01 is four-channel scan.
// - Bit 3 at 1 repeats the selected scan continuously.
// - Bits 2:0 select channels; 011 in four-channel scan means 0 to 3.
// - Clearing start bit 13 stops conversion and returns to idle.
// - Setting start bit begins conversion with the chosen settings.
// - Single mode clears the start bit itself when conversion ends.
// - Trigger field at bits 7:4 picks the start source; bits 3:0 are unused; reset 0000.
// - Field at bits 11:8 picks the group-1 trigger in 2-ch scan; bits 15:12 are unused.
// - Module-stop bit 0 at 1 halts the converter unit; 0 lets it run.
// - Each conversion result is stored in its channel's result register.
module adcsc_scan_ctrl
    import adcsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] trig_pin,
    input wire logic xfer_read,
    input wire logic [15:0] sample_data,
    output logic sample_req,
    output logic [2:0] sample_chan,
    output logic conv_clk_en,
    output logic conversion_end_irq
);
    logic [7:0] stop_q;
    logic [14:0] csr_q;
    logic flag_q;
    logic start_q;
    logic [15:0] trig_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic rd_seen_q;
    logic sample_req_q;
    logic [2:0] chan_q;
    logic group_q;
    logic [6:0] cnt_q;
    logic [4:0] div_q;
    logic clk_en_q;
    logic irq_q;
    logic [15:0] ts1_q;
    logic [15:0] ts2_q;
    logic [15:0] ts3_q;
    logic [15:0] tlvl_q;
    adcsc_seq_e state_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    adcsc_res_if res ();

    adcsc_result_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .res(res)
    );

    logic acc;
    logic done;
    logic wr_done;
    logic hit;
    logic is_res;
    logic [31:0] rd_mux;
    logic ie;
    logic trgen;
    logic flagctl;
    logic cont;
    logic stop0;
    logic [1:0] mode;
    logic [2:0] chan_sel;
    logic [4:0] div_n;
    logic [6:0] len;
    logic run;
    logic tick;
    logic conv_end;
    logic at_last;
    logic pass_end;
    logic group_end;
    logic set_flag;
    logic sw_clr;
    logic xfer_clr;
    logic sw_start;
    logic sw_stop;
    logic [15:0] trig_rise;
    logic [3:0] trig_src;
    logic trig_fire;
    logic [2:0] first_g0;
    logic [2:0] last_g0;
    logic [2:0] first_g1;
    logic [2:0] last_g1;
    logic [2:0] last_chan;

    assign ie = csr_q[BIT_IE];
    assign trgen = csr_q[BIT_TRGEN];
    assign flagctl = csr_q[BIT_FLAGCTL];
    assign cont = csr_q[BIT_CONT];
    assign mode = csr_q[MODE_LSB +: 2];
    assign chan_sel = csr_q[CHSEL_LSB +: 3];
    assign stop0 = stop_q[BIT_STOP0];

    // APB answer: pready rises in the second access cycle, so the
    // result store's registered read data is always in time.
    assign acc = psel && penable;
    assign done = acc && pready_q;
    assign wr_done = done && pwrite;
    assign res.rd_idx = paddr[3:2];

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        hit = 1'b1;
        is_res = 1'b0;
        case (paddr)
            OFS_STOP: rd_mux = {24'h00_0000, stop_q};
            OFS_CSR: rd_mux = {16'h0000, flag_q, csr_q};
            OFS_START: rd_mux = {18'h0_0000, start_q, 13'h0000};
            OFS_TRIG: rd_mux = {16'h0000, trig_q};
            OFS_RES0, OFS_RES1, OFS_RES2, OFS_RES3:
            begin
                rd_mux = {16'h0000, res.rd_data};
                is_res = 1'b1;
            end
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= acc && !pready_q;
            if (acc && !pready_q)
            begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_q <= !hit;
            end
        end
    end

    // Software-written registers; unmapped writes change nothing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stop_q <= STOP_RST;
            csr_q <= CSR_RST[14:0];
            trig_q <= TRIG_RST;
        end
        else if (wr_done)
        begin
            if (paddr == OFS_STOP)
            begin
                stop_q <= pwdata[7:0];
            end
            if (paddr == OFS_CSR)
            begin
                csr_q <= pwdata[14:0] & CSR_WMASK[14:0];
            end
            if (paddr == OFS_TRIG)
            begin
                trig_q <= pwdata[15:0];
            end
        end
    end

    // Software may only clear the flag by a write that follows a read of 1.
    assign sw_clr = wr_done && paddr == OFS_CSR && !pwdata[BIT_FLAG]
        && rd_seen_q;
    assign xfer_clr = done && !pwrite && is_res && xfer_read && ie;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_seen_q <= 1'b0;
        end
        else if (done && paddr == OFS_CSR)
        begin
            rd_seen_q <= !pwrite && prdata_q[BIT_FLAG];
        end
    end

    // A hardware set in the same cycle as a clear wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= 1'b0;
        end
        else if (set_flag)
        begin
            flag_q <= 1'b1;
        end
        else if (sw_clr || xfer_clr)
        begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
            clk_en_q <= 1'b0;
        end
        else
        begin
            irq_q <= flag_q && ie;
            clk_en_q <= !stop0;
        end
    end

    // Trigger pins: three stages; a level counts when stages 2 and 3 agree.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ts1_q <= 16'h0000;
            ts2_q <= 16'h0000;
            ts3_q <= 16'h0000;
            tlvl_q <= 16'h0000;
        end
        else
        begin
            ts1_q <= trig_pin;
            ts2_q <= ts1_q;
            ts3_q <= ts2_q;
            tlvl_q <= (ts2_q & ts3_q) | (tlvl_q & (ts2_q | ts3_q));
        end
    end

    assign trig_rise = ts2_q & ts3_q & ~tlvl_q;
    assign trig_src = (state_q == SEQ_WAIT) ? trig_q[TRG_G1_LSB +: 4]
        : trig_q[TRG_U0_LSB +: 4];
    assign trig_fire = trgen && !stop0 && trig_rise[trig_src];

    // Channel ranges; only the low two bits index a result word.
    always_comb
    begin
        first_g0 = {chan_sel[2], 2'h0};
        last_g0 = chan_sel;
        first_g1 = {chan_sel[2], 2'h2};
        last_g1 = {chan_sel[2], 1'b1, chan_sel[0]};
        if (mode == MODE_SINGLE)
        begin
            first_g0 = chan_sel;
        end
        else if (mode == MODE_SCAN2)
        begin
            last_g0 = {chan_sel[2], 1'b0, chan_sel[0]};
        end
    end

    assign last_chan = group_q ? last_g1 : last_g0;

    always_comb
    begin
        case (csr_q[CKS_LSB +: 2])
            2'h0: div_n = DIV_CKS0;
            2'h1: div_n = DIV_CKS1;
            2'h2: div_n = DIV_CKS2;
            default: div_n = DIV_CKS3;
        endcase
    end

    assign len = csr_q[BIT_STATES] ? LEN_LONG : LEN_SHORT;
    assign run = state_q == SEQ_CONV && !stop0;
    assign tick = run && div_q == 5'(div_n - 5'h01);
    assign conv_end = tick && cnt_q == 7'(len - 7'h01);
    assign at_last = conv_end && chan_q == last_chan;
    assign pass_end = at_last && (mode != MODE_SCAN2 || group_q);
    assign group_end = at_last && mode == MODE_SCAN2 && !group_q;
    assign set_flag = pass_end || (group_end && !flagctl);

    assign sw_start = wr_done && paddr == OFS_START && pwdata[BIT_START];
    assign sw_stop = wr_done && paddr == OFS_START && !pwdata[BIT_START];

    assign res.wr_en = conv_end;
    assign res.wr_idx = chan_q[1:0];
    assign res.wr_data = sample_data;

    // Conversion clock enable, restarted with every conversion.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= 5'h00;
        end
        else if (!run || sample_req_q || tick)
        begin
            div_q <= 5'h00;
        end
        else
        begin
            div_q <= 5'(div_q + 5'h01);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 7'h00;
        end
        else if (state_q != SEQ_CONV || conv_end)
        begin
            cnt_q <= 7'h00;
        end
        else if (tick)
        begin
            cnt_q <= 7'(cnt_q + 7'h01);
        end
    end

    // Sequencer. Mode 11 behaves as four-channel scan.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= SEQ_IDLE;
            start_q <= 1'b0;
            chan_q <= 3'h0;
            group_q <= 1'b0;
            sample_req_q <= 1'b0;
        end
        else
        begin
            sample_req_q <= 1'b0;
            if (sw_stop)
            begin
                start_q <= 1'b0;
                state_q <= SEQ_IDLE;
            end
            else
            begin
                case (state_q)
                    SEQ_IDLE:
                    begin
                        if (sw_start || trig_fire)
                        begin
                            start_q <= 1'b1;
                            group_q <= 1'b0;
                            chan_q <= first_g0;
                            sample_req_q <= 1'b1;
                            state_q <= SEQ_CONV;
                        end
                    end
                    SEQ_CONV:
                    begin
                        if (conv_end && !at_last)
                        begin
                            chan_q <= 3'(chan_q + 3'h1);
                            sample_req_q <= 1'b1;
                        end
                        else if (at_last && mode == MODE_SINGLE)
                        begin
                            start_q <= 1'b0;
                            state_q <= SEQ_IDLE;
                        end
                        else if (group_end && trgen)
                        begin
                            state_q <= SEQ_WAIT;
                        end
                        else if (group_end)
                        begin
                            group_q <= 1'b1;
                            chan_q <= first_g1;
                            sample_req_q <= 1'b1;
                        end
                        else if (pass_end && cont)
                        begin
                            group_q <= 1'b0;
                            chan_q <= first_g0;
                            sample_req_q <= 1'b1;
                        end
                        else if (pass_end)
                        begin
                            start_q <= 1'b0;
                            state_q <= SEQ_IDLE;
                        end
                    end
                    SEQ_WAIT:
                    begin
                        if (trig_fire)
                        begin
                            group_q <= 1'b1;
                            chan_q <= first_g1;
                            sample_req_q <= 1'b1;
                            state_q <= SEQ_CONV;
                        end
                    end
                    default: state_q <= SEQ_IDLE;
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sample_req = sample_req_q;
    assign sample_chan = chan_q;
    assign conv_clk_en = clk_en_q;
    assign conversion_end_irq = irq_q;

    // Helper: cycles since a conversion began, and whether it was disturbed.
    logic [8:0] age_q;
    logic stall_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            age_q <= 9'h000;
            stall_q <= 1'b1;
        end
        else
        begin
            age_q <= sample_req_q ? 9'h001 : 9'(age_q + 9'h001);
            stall_q <= !sample_req_q && (stall_q || stop0
                || csr_q[CKS_LSB +: 2] != 2'h0 || csr_q[BIT_STATES]);
        end
    end

    sequence s_pass_done;
        pass_end && mode == MODE_SCAN4 && !sw_stop;
    endsequence

    a_flag_on_scan: assert property (s_pass_done |=> flag_q)
        else $error("End flag not set after scan pass.");
    a_clear_needs_read: assert property (flag_q && !rd_seen_q
        && !xfer_clr && wr_done && paddr == OFS_CSR |=> flag_q)
        else $error("End flag cleared without prior read.");
    a_irq_gated: assert property (!ie [*2] |-> !irq_q)
        else $error("Interrupt active while disabled.");
    a_trig_ignored: assert property (state_q == SEQ_IDLE && !trgen
        && !sw_start |=> state_q == SEQ_IDLE && !start_q)
        else $error("Trigger started conversion while disabled.");
    a_len_fast: assert property (conv_end && !stall_q
        |-> age_q == 9'h0c8)
        else $error("Conversion did not last 50 states at divide four.");
    a_stop_idle: assert property (sw_stop ##1 !trig_fire
        |-> state_q == SEQ_IDLE && !start_q [*2])
        else $error("Start bit clear did not stop conversion.");
    a_single_end: assert property (at_last && mode == MODE_SINGLE
        |=> !start_q && state_q == SEQ_IDLE)
        else $error("Single mode did not clear start bit.");
    a_cont_restart: assert property (s_pass_done ##0 cont
        |=> sample_req_q && chan_q == first_g0 && start_q)
        else $error("Continuous scan did not restart.");
    a_module_stop: assert property (stop0 [*2] |-> !clk_en_q && !tick)
        else $error("Stopped unit still clocked.");
endmodule : adcsc_scan_ctrl

// *** verification/adcsc_front_model.sv ***
`timescale 1ns/1ps
// Sampling front end. Each sample request latches the channel, and the
// code of that channel is held until the next request.
module adcsc_front_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_req,
    input wire logic [2:0] sample_chan,
    output logic [15:0] sample_data
);
    logic held_q;
    logic [2:0] chan_q;
    logic [15:0] noise_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            held_q <= 1'b0;
            chan_q <= 3'h0;
        end
        else if (sample_req)
        begin
            held_q <= 1'b1;
            chan_q <= sample_chan;
        end
    end

    // Before the first request nothing has been sampled, so the line
    // toggles every cycle and a stale value cannot pass for a result.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            noise_q <= 16'h5555;
        else
            noise_q <= ~noise_q;
    end

    assign sample_data = held_q ? {8'ha5, 5'h00, chan_q} : noise_q;
endmodule : adcsc_front_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import adcsc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, xfer_read;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] trig_pin, sample_data;
    logic sample_req, conv_clk_en, conversion_end_irq, err;
    logic [2:0] sample_chan;
    logic [2:0] chq[$];
    int tq[$];
    int errors, checked, cyc, n, i;

    adcsc_scan_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_pin(trig_pin), .xfer_read(xfer_read),
        .sample_data(sample_data), .sample_req(sample_req),
        .sample_chan(sample_chan), .conv_clk_en(conv_clk_en),
        .conversion_end_irq(conversion_end_irq));

    adcsc_front_model i_front (.pclk(pclk), .presetn(presetn),
        .sample_req(sample_req), .sample_chan(sample_chan),
        .sample_data(sample_data));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (sample_req === 1'b1)
        begin
            chq.push_back(sample_chan);
            tq.push_back(cyc);
        end
    end

    task results;
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : check

    // The request is held until pready is seen at an edge, then released,
    // and one idle edge passes so that the next call never overlaps it.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        check({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rdc

    task wait_idle;
        int k;
        k = 0;
        do
        begin
            apb(1'b0, OFS_START, 32'h0);
            k++;
        end
        while (rd[BIT_START] !== 1'b0 && k < 400);
        check(rd, 32'h0);
    endtask : wait_idle

    task chk_scan(input int cnt, input int gap);
        int k;
        check(32'(chq.size()), 32'(cnt));
        for (k = 0; k < cnt && k < chq.size(); k++)
        begin
            check({29'h0, chq[k]}, 32'(k % 4));
            if (k % 4 != 0)
                check(32'(tq[k] - tq[k - 1]), 32'(gap));
        end
    endtask : chk_scan

    task pulse_trig(input logic [15:0] m);
        trig_pin <= m;
        repeat (3) @(posedge pclk);
        trig_pin <= 16'h0000;
    endtask : pulse_trig

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, xfer_read} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        trig_pin = 16'h0000;
        {errors, checked, cyc} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({31'h0, conv_clk_en}, 32'h0);
        rdc(OFS_STOP, 32'hff);
        rdc(OFS_CSR, 32'h0);
        rdc(OFS_START, 32'h0);
        rdc(OFS_TRIG, 32'h0);
        rdc(8'h20, 32'h0);
        check({31'h0, err}, 32'h1);
        wr(OFS_TRIG, 32'hffff);
        rdc(OFS_TRIG, 32'hffff);
        wr(OFS_TRIG, 32'h0030);
        wr(OFS_STOP, 32'hfe);
        @(posedge pclk);
        check({31'h0, conv_clk_en}, 32'h1);
        wr(OFS_CSR, 32'h0002);
        pulse_trig(16'h0008);
        repeat (20) @(posedge pclk);
        check(32'(chq.size()), 32'h0);
        wr(OFS_CSR, 32'h0802);
        pulse_trig(16'h0008);
        repeat (10) @(posedge pclk);
        check(32'(chq.size()), 32'h1);
        check({29'h0, chq[0]}, 32'h2);
        wait_idle();
        rdc(OFS_RES2, 32'ha502);
        rdc(OFS_CSR, 32'h8802);
        wr(OFS_CSR, 32'h0002);
        chq.delete();
        tq.delete();
        wr(OFS_CSR, 32'h4013);
        wr(OFS_START, 32'h2000);
        wait_idle();
        chk_scan(4, 201);
        for (i = 0; i < 4; i++)
            rdc(OFS_RES0 + 8'(i * 4), 32'ha500 + 32'(i));
        check({31'h0, conversion_end_irq}, 32'h1);
        wr(OFS_CSR, 32'h4013);
        rdc(OFS_CSR, 32'hc013);
        wr(OFS_CSR, 32'h4013);
        rdc(OFS_CSR, 32'h4013);
        check({31'h0, conversion_end_irq}, 32'h0);
        wr(OFS_START, 32'h2000);
        wait_idle();
        xfer_read <= 1'b1;
        apb(1'b0, OFS_RES3, 32'h0);
        xfer_read <= 1'b0;
        check(rd, 32'ha503);
        rdc(OFS_CSR, 32'h4013);
        chq.delete();
        tq.delete();
        wr(OFS_CSR, 32'h01db);
        wr(OFS_START, 32'h2000);
        repeat (1500) if (chq.size() < 6) @(posedge pclk);
        chk_scan(6, 129);
        rdc(OFS_CSR, 32'h81db);
        check({31'h0, conversion_end_irq}, 32'h0);
        wr(OFS_START, 32'h0);
        repeat (2) @(posedge pclk);
        n = chq.size();
        repeat (300) @(posedge pclk);
        check(32'(chq.size()), 32'(n));
        rdc(OFS_START, 32'h0);
        chq.delete();
        tq.delete();
        wr(OFS_CSR, 32'h0223);
        wr(OFS_START, 32'h2000);
        repeat (700) if (chq.size() < 3) @(posedge pclk);
        rdc(OFS_CSR, 32'h0223);
        wait_idle();
        chk_scan(4, 201);
        rdc(OFS_CSR, 32'h8223);
        chq.delete();
        wr(OFS_CSR, 32'h0823);
        pulse_trig(16'h0008);
        repeat (700) if (chq.size() < 2) @(posedge pclk);
        repeat (250) @(posedge pclk);
        pulse_trig(16'h0008);
        repeat (20) @(posedge pclk);
        check(32'(chq.size()), 32'h2);
        rdc(OFS_CSR, 32'h8823);
        pulse_trig(16'h0001);
        repeat (10) @(posedge pclk);
        check(32'(chq.size()), 32'h3);
        check({29'h0, chq[2]}, 32'h2);
        wait_idle();
        check(32'(chq.size()), 32'h4);
        check({29'h0, chq[3]}, 32'h3);
        wr(OFS_STOP, 32'hff);
        @(posedge pclk);
        check({31'h0, conv_clk_en}, 32'h0);
        results();
    end

    // The tests take about 4700 cycles; this limit leaves ample margin.
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        results();
    end
endmodule : tb_top
